// file: logic/adcc_control.sv
/*
  Converter control register, channel enable register and conversion
  sequencer, reached over a classic Wishbone slave.
  Assumes a synchronous active-high reset, a converter that answers each
  one-cycle convReq with a one-cycle convDone and data, and an external
  start pin asynchronous to clk.
*/
// The implementer's own choice: the Wishbone register port.
// Summary of operation
// - The control register lives at offset 0x20, is read/write and resets to all zero.
// - Bit 31 picks two's complement (1) or unsigned (0) results.
// - Bit 11 set runs conversions; clearing it stops them and idles the sequencer.
// - The start flag is set by a software write of 1 or by a qualified pin event.
// - Hardware clears the start flag at the end of a single conversion or single scan.
// - Continuous scan repeats until software writes 0, reset, or no channel is left enabled.
// - Bit 10 selects differential (1) or single-ended (0) input.
// - Differential pair n uses input 2n as plus and 2n+1 as minus.
// - In differential mode only even channels are enabled and results go there.
// - Bit 9 makes each finished conversion raise a DMA request.
// - Two's complement results carry the sign in bits 15:12, unsigned ones zero.
// - Bits 3:2 select single, single-cycle scan or continuous scan; 01 is reserved.
// - In hardware trigger mode a qualified pin event sets the start flag, in single-cycle scan mode only.
`include "adcc_defines.svh"
`default_nettype none

module adcc_control
  import adcc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        wbCyc,
  input  wire logic        wbStb,
  input  wire logic        wbWe,
  input  wire logic [7:0]  wbAdr,
  input  wire logic [3:0]  wbSel,
  input  wire logic [31:0] wbDatIn,
  output logic [31:0]      wbDatOut,
  output logic             wbAck,
  input  wire logic        externalStartPin,
  output logic             convReq,
  output logic [2:0]       convChannel,
  output logic             convDiff,
  input  wire logic        convDone,
  input  wire logic [11:0] convData,
  output logic             converterEnable,
  output logic             conversionInterruptEnable,
  output logic             resultWrite,
  output logic [2:0]       resultIndex,
  output logic [15:0]      resultData,
  output logic             dmaRequest
);

  adcc_ctrl_s state_ff;
  adcc_ctrl_s nxt_state;

  logic       trigEvent;
  logic       accept;
  logic       req;
  logic       wrCtrl;
  logic       wrChen;
  logic       swSet;
  logic       swClr;
  logic       trigSet;
  logic       hwClr;
  logic [7:0] mask;
  logic [3:0] found;

  // Lowest enabled channel at or above from; bit 3 flags a hit
  function automatic logic [3:0] findNext(input logic [7:0] m,
                                          input logic [3:0] from);
    findNext = 4'h0;
    for (int i = 7; i >= 0; i--) begin
      if (m[i] && (4'(i) >= from)) begin
        findNext = {1'b1, 3'(i)};
      end
    end
  endfunction

  // Readback of the control register
  function automatic logic [31:0] ctrlWord(input adcc_ctrl_s s);
    ctrlWord = `ADCC_CTRL_RST;
    ctrlWord[`ADCC_FMT_BIT]                  = s.fmtSigned;
    ctrlWord[`ADCC_START_BIT]                = s.startFlag;
    ctrlWord[`ADCC_DIFF_BIT]                 = s.diffMode;
    ctrlWord[`ADCC_DMA_BIT]                  = s.dmaEn;
    ctrlWord[`ADCC_EXTERNAL_TRIGGER_ENABLE_BIT]                = s.trigEn;
    ctrlWord[`ADCC_TCOND_HI:`ADCC_TCOND_LO]  = s.trigCond;
    ctrlWord[`ADCC_MODE_HI:`ADCC_MODE_LO]    = s.opMode;
    ctrlWord[`ADCC_INTEN_BIT]                = s.intEn;
    ctrlWord[`ADCC_CONVEN_BIT]               = s.convEn;
  endfunction

  function automatic logic hitOffset(input logic [7:0] adr,
                                     input logic [7:0] off);
    hitOffset = (adr[7:2] == off[7:2]);
  endfunction

  adcc_start_pin_qual u_pin (
    .clk              (clk),
    .rst              (rst),
    .externalStartPin (externalStartPin),
    .trigCond         (state_ff.trigCond),
    .trigEvent        (trigEvent)
  );

  assign accept = convDone && (state_ff.seq == ADCC_CONVERT);

  adcc_result_fmt u_fmt (
    .clk         (clk),
    .rst         (rst),
    .accept      (accept),
    .convData    (convData),
    .chan        (state_ff.chan),
    .fmtSigned   (state_ff.fmtSigned),
    .dmaEn       (state_ff.dmaEn),
    .resultWrite (resultWrite),
    .resultIndex (resultIndex),
    .resultData  (resultData),
    .dmaRequest  (dmaRequest)
  );

  always_comb begin
    nxt_state         = state_ff;
    nxt_state.ack     = 1'b0;
    nxt_state.convReq = 1'b0;
    hwClr             = 1'b0;
    found             = 4'h0;
    req    = wbCyc && wbStb && !state_ff.ack;
    wrCtrl = req && wbWe && hitOffset(wbAdr, `ADCC_CTRL_OFF);
    wrChen = req && wbWe && hitOffset(wbAdr, `ADCC_CHEN_OFF);
    swSet  = wrCtrl && wbSel[1] && wbDatIn[`ADCC_START_BIT];
    swClr  = wrCtrl && wbSel[1] && !wbDatIn[`ADCC_START_BIT];
    // Pin start only counts in single-cycle scan with the trigger on
    trigSet = trigEvent && state_ff.trigEn &&
              (state_ff.opMode == `ADCC_MODE_SCAN);
    // Even channels only in differential mode
    mask = state_ff.chanEn &
           (state_ff.diffMode ? `ADCC_EVEN_MASK : `ADCC_ALL_MASK);

    // Bus side
    if (req) begin
      nxt_state.ack = 1'b1;
      if (hitOffset(wbAdr, `ADCC_CTRL_OFF)) begin
        nxt_state.rdata = ctrlWord(state_ff);
      end else if (hitOffset(wbAdr, `ADCC_CHEN_OFF)) begin
        nxt_state.rdata = {24'h00_0000, state_ff.chanEn};
      end else begin
        nxt_state.rdata = 32'h0000_0000;
      end
    end
    if (wrCtrl && wbSel[3]) begin
      nxt_state.fmtSigned = wbDatIn[`ADCC_FMT_BIT];
    end
    if (wrCtrl && wbSel[1]) begin
      nxt_state.diffMode = wbDatIn[`ADCC_DIFF_BIT];
      nxt_state.dmaEn    = wbDatIn[`ADCC_DMA_BIT];
      nxt_state.trigEn   = wbDatIn[`ADCC_EXTERNAL_TRIGGER_ENABLE_BIT];
    end
    if (wrCtrl && wbSel[0]) begin
      nxt_state.trigCond = wbDatIn[`ADCC_TCOND_HI:`ADCC_TCOND_LO];
      nxt_state.opMode   = wbDatIn[`ADCC_MODE_HI:`ADCC_MODE_LO];
      nxt_state.intEn    = wbDatIn[`ADCC_INTEN_BIT];
      nxt_state.convEn   = wbDatIn[`ADCC_CONVEN_BIT];
    end
    if (wrChen && wbSel[0]) begin
      nxt_state.chanEn = wbDatIn[7:0];
    end

    // Sequencer
    unique case (state_ff.seq)
      ADCC_IDLE: begin
        if (state_ff.startFlag && !swClr) begin
          found = findNext(mask, 4'h0);
          if (found[3]) begin
            nxt_state.chan    = found[2:0];
            nxt_state.convReq = 1'b1;
            nxt_state.seq     = ADCC_CONVERT;
          end else begin
            // Nothing enabled: the run ends at once
            hwClr = 1'b1;
          end
        end
      end
      ADCC_CONVERT: begin
        if (swClr || !state_ff.startFlag) begin
          nxt_state.seq = ADCC_IDLE;
        end else if (convDone) begin
          found = findNext(mask, {1'b0, state_ff.chan} + 4'h1);
          if (state_ff.opMode == `ADCC_MODE_SINGLE ||
              state_ff.opMode == `ADCC_MODE_RSV) begin
            hwClr         = 1'b1;
            nxt_state.seq = ADCC_IDLE;
          end else if (found[3]) begin
            nxt_state.chan    = found[2:0];
            nxt_state.convReq = 1'b1;
          end else if (state_ff.opMode == `ADCC_MODE_CONT) begin
            found = findNext(mask, 4'h0);
            if (found[3]) begin
              nxt_state.chan    = found[2:0];
              nxt_state.convReq = 1'b1;
            end else begin
              nxt_state.seq = ADCC_IDLE;
            end
          end else begin
            hwClr         = 1'b1;
            nxt_state.seq = ADCC_IDLE;
          end
        end
      end
      default: begin
        nxt_state.seq = ADCC_IDLE;
      end
    endcase

    // A set in the same cycle as any clear wins
    if (swSet || trigSet) begin
      nxt_state.startFlag = 1'b1;
    end else if (swClr || hwClr) begin
      nxt_state.startFlag = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign wbDatOut                  = state_ff.rdata;
  assign wbAck                     = state_ff.ack;
  assign convReq                   = state_ff.convReq;
  assign convChannel               = state_ff.chan;
  assign convDiff                  = state_ff.diffMode;
  assign converterEnable           = state_ff.convEn;
  assign conversionInterruptEnable = state_ff.intEn;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence swStop;
    wbCyc && wbStb && !wbAck && wbWe && hitOffset(wbAdr, `ADCC_CTRL_OFF)
    && wbSel[1] && !wbDatIn[`ADCC_START_BIT] && !trigSet;
  endsequence

  sequence oneShotDone;
    accept && state_ff.opMode == `ADCC_MODE_SINGLE && !swSet && !trigSet;
  endsequence

  reset_zero_a: assert property (
    $past(rst) |-> (ctrlWord(state_ff) == `ADCC_CTRL_RST) && !wbAck)
    else $error("Control register not zero after reset");

  reserved_zero_a: assert property (
    wbAck && !wbWe && hitOffset(wbAdr, `ADCC_CTRL_OFF)
    |-> wbDatOut[`ADCC_RSV_HI:`ADCC_RSV_LO] == 19'h0_0000)
    else $error("Reserved control bits read nonzero");

  sw_stop_a: assert property (
    swStop |=> !state_ff.startFlag ##1 (state_ff.seq == ADCC_IDLE))
    else $error("Software stop did not idle the sequencer");

  single_clear_a: assert property (
    oneShotDone |=> !state_ff.startFlag && state_ff.seq == ADCC_IDLE)
    else $error("Start flag not cleared after single conversion");

  cont_keeps_a: assert property (
    accept && state_ff.opMode == `ADCC_MODE_CONT && mask != 8'h00
    && !swClr |=> state_ff.startFlag && convReq)
    else $error("Continuous scan stopped by itself");

  trig_set_a: assert property (
    trigSet |=> state_ff.startFlag)
    else $error("Qualified pin event did not set start flag");

  diff_even_a: assert property (
    convReq && convDiff |-> !convChannel[0])
    else $error("Differential conversion on an odd channel");

  read_ack_a: assert property (
    wbCyc && wbStb && !wbAck |=> wbAck ##1 !wbAck)
    else $error("Bus ack not a single cycle after request");

  start_convert_a: assert property (
    state_ff.seq == ADCC_IDLE && state_ff.startFlag && mask != 8'h00
    && !swClr |=> convReq && state_ff.seq == ADCC_CONVERT)
    else $error("Set start flag did not start a conversion");

endmodule

`default_nettype wire

// file: logic/adcc_defines.svh
/*
  Register offsets, field positions, reset values and filter counts of the
  converter control block.
  Assumes inclusion by bare name from every file of the block.
*/
`ifndef ADCC_DEFINES_SVH
`define ADCC_DEFINES_SVH

// Byte offsets on the register bus
`define ADCC_CTRL_OFF       8'h20
`define ADCC_CHEN_OFF       8'h24

// Control register field positions
`define ADCC_FMT_BIT        31
`define ADCC_RSV_HI         30
`define ADCC_RSV_LO         12
`define ADCC_START_BIT      11
`define ADCC_DIFF_BIT       10
`define ADCC_DMA_BIT        9
`define ADCC_EXTERNAL_TRIGGER_ENABLE_BIT      8
`define ADCC_TCOND_HI       7
`define ADCC_TCOND_LO       6
`define ADCC_MODE_HI        3
`define ADCC_MODE_LO        2
`define ADCC_INTEN_BIT      1
`define ADCC_CONVEN_BIT     0

// Reset values
`define ADCC_CTRL_RST       32'h0000_0000
`define ADCC_CHEN_RST       8'h00

// Operation mode codes
`define ADCC_MODE_SINGLE    2'h0
`define ADCC_MODE_RSV       2'h1
`define ADCC_MODE_SCAN      2'h2
`define ADCC_MODE_CONT      2'h3

// Trigger condition codes
`define ADCC_TC_LOW         2'h0
`define ADCC_TC_HIGH        2'h1
`define ADCC_TC_FALL        2'h2
`define ADCC_TC_RISE        2'h3

// Least stable time of the start pin, in clock cycles
`define ADCC_LEVEL_CYCLES   4'h8
`define ADCC_EDGE_CYCLES    4'h4

// Even-channel mask used in differential mode
`define ADCC_EVEN_MASK      8'h55
`define ADCC_ALL_MASK       8'hff

`endif

// file: logic/adcc_pkg.sv
/*
  Types of the converter control block: sequencer states and the state
  records of each module.
  Assumes adcc_defines.svh is on the include path.
*/
`default_nettype none

package adcc_pkg;

  typedef enum logic [1:0] {
    ADCC_IDLE    = 2'h0,
    ADCC_CONVERT = 2'h1
  } adcc_seq_e;

  typedef struct packed {
    logic        fmtSigned;
    logic        startFlag;
    logic        diffMode;
    logic        dmaEn;
    logic        trigEn;
    logic [1:0]  trigCond;
    logic [1:0]  opMode;
    logic        intEn;
    logic        convEn;
    logic [7:0]  chanEn;
    adcc_seq_e   seq;
    logic [2:0]  chan;
    logic        convReq;
    logic        ack;
    logic [31:0] rdata;
  } adcc_ctrl_s;

  typedef struct packed {
    logic       sync1;
    logic       sync2;
    logic [3:0] stableCnt;
    logic       filtLevel;
    logic       trigEvent;
  } adcc_pin_s;

  typedef struct packed {
    logic        resultWrite;
    logic [2:0]  resultIndex;
    logic [15:0] resultData;
    logic        dmaRequest;
  } adcc_fmt_s;

endpackage

`default_nettype wire

// file: logic/adcc_start_pin_qual.sv
/*
  Qualifies the external start pin: two-flop synchroniser, stability
  filter, then level or edge detection as the trigger condition selects.
  Assumes the pin is asynchronous to clk.
*/
`include "adcc_defines.svh"
`default_nettype none

module adcc_start_pin_qual
  import adcc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       externalStartPin,
  input  wire logic [1:0] trigCond,
  output logic            trigEvent
);

  adcc_pin_s state_ff;
  adcc_pin_s nxt_state;

  always_comb begin
    nxt_state           = state_ff;
    nxt_state.sync1     = externalStartPin;
    nxt_state.sync2     = state_ff.sync1;
    nxt_state.trigEvent = 1'b0;
    if (state_ff.sync2 != state_ff.filtLevel) begin
      // Edge filter: a new level counts only once held for the edge time
      if (state_ff.stableCnt >= `ADCC_EDGE_CYCLES - 4'h1) begin
        nxt_state.filtLevel = state_ff.sync2;
        nxt_state.stableCnt = 4'h0;
        if (trigCond == `ADCC_TC_RISE && state_ff.sync2) begin
          nxt_state.trigEvent = 1'b1;
        end
        if (trigCond == `ADCC_TC_FALL && !state_ff.sync2) begin
          nxt_state.trigEvent = 1'b1;
        end
      end else begin
        nxt_state.stableCnt = state_ff.stableCnt + 4'h1;
      end
    end else begin
      nxt_state.stableCnt = 4'h0;
    end
    // Level trigger keeps firing while the settled level matches
    if (state_ff.sync2 == state_ff.filtLevel) begin
      if (trigCond == `ADCC_TC_LOW && !state_ff.filtLevel) begin
        nxt_state.trigEvent = 1'b1;
      end
      if (trigCond == `ADCC_TC_HIGH && state_ff.filtLevel) begin
        nxt_state.trigEvent = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign trigEvent = state_ff.trigEvent;

endmodule

`default_nettype wire

// file: logic/adcc_result_fmt.sv
/*
  Formats each finished conversion into a 16-bit result word, names the
  result register it belongs to and raises the DMA request.
  Assumes accept is a one-cycle pulse on the same clock.
*/
`include "adcc_defines.svh"
`default_nettype none

module adcc_result_fmt
  import adcc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        accept,
  input  wire logic [11:0] convData,
  input  wire logic [2:0]  chan,
  input  wire logic        fmtSigned,
  input  wire logic        dmaEn,
  output logic             resultWrite,
  output logic [2:0]       resultIndex,
  output logic [15:0]      resultData,
  output logic             dmaRequest
);

  adcc_fmt_s state_ff;
  adcc_fmt_s nxt_state;

  // Converter code is offset binary; flipping the top bit gives two's
  // complement, then the sign fills the upper nibble
  function automatic logic [15:0] formatResult(input logic [11:0] raw,
                                               input logic        sgn);
    logic [11:0] tc;
    tc = {~raw[11], raw[10:0]};
    if (sgn) begin
      formatResult = {{4{tc[11]}}, tc};
    end else begin
      formatResult = {4'h0, raw};
    end
  endfunction

  always_comb begin
    nxt_state             = state_ff;
    nxt_state.resultWrite = accept;
    nxt_state.dmaRequest  = accept && dmaEn;
    if (accept) begin
      nxt_state.resultIndex = chan;
      nxt_state.resultData  = formatResult(convData, fmtSigned);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign resultWrite = state_ff.resultWrite;
  assign resultIndex = state_ff.resultIndex;
  assign resultData  = state_ff.resultData;
  assign dmaRequest  = state_ff.dmaRequest;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  dma_request_a: assert property (
    accept |=> (dmaRequest == $past(dmaEn)) && resultWrite)
    else $error("DMA request does not follow the enable");

  sign_fill_a: assert property (
    resultWrite |-> (resultData[15:12] ==
                     ($past(fmtSigned) ? {4{resultData[11]}} : 4'h0)))
    else $error("Upper result nibble wrong for format");

endmodule

`default_nettype wire

// file: sim/adcc_conv_model.sv
/*
  Behavioural converter on the far side of the control block: answers each
  convReq with one convDone pulse, either promptly or after a long run.
  Assumes convReq is a one-cycle pulse on clk and rst is synchronous.
*/
`default_nettype none

module adcc_conv_model (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        convReq,
  input  wire logic        slow,
  output logic             convDone,
  output logic [11:0]      convData
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [5:0] cnt;
  logic       busy;

  // Data walks every cycle, so a stale code never passes for a result
  always_ff @(posedge clk) begin
    convDone <= 1'b0;
    convData <= rst ? 12'h000 : convData + 12'h3a7;
    if (rst) begin
      busy <= 1'b0;
      cnt  <= 6'h00;
    end else if (convReq) begin
      busy <= 1'b1;
      cnt  <= slow ? 6'h1e : 6'h01;
    end else if (busy) begin
      cnt <= cnt - 6'h01;
      if (cnt == 6'h01) begin
        convDone <= 1'b1;
        busy     <= 1'b0;
      end
    end
  end

endmodule

`default_nettype wire

// file: sim/tb_adcc_control.sv
/*
  Self-checking bench of the converter control block: Wishbone master,
  a scan model in queues, and a monitor that checks every conversion.
  Assumes the converter model in adcc_conv_model.sv.
*/
`include "adcc_defines.svh"
`default_nettype none

module tb_adcc_control;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clk, rst, wbCyc, wbStb, wbWe, wbAck, pin, slow;
  logic [7:0]  wbAdr, en;
  logic [3:0]  wbSel;
  logic [31:0] wbDatIn, wbDatOut, c, q;
  logic        convReq, convDiff, convDone, convEn, intEn;
  logic        resultWrite, dmaRequest;
  logic [2:0]  convChannel, resultIndex;
  logic [11:0] convData;
  logic [15:0] resultData;
  int          n_errors, total_checks, reqIdx, resIdx, seed;
  int          chans[$];
  logic [11:0] dq[$];
  logic        running, curFmt, curDma, curDiff;

  adcc_control DUT (.clk(clk), .rst(rst), .wbCyc(wbCyc), .wbStb(wbStb),
    .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbDatIn(wbDatIn),
    .wbDatOut(wbDatOut), .wbAck(wbAck), .externalStartPin(pin),
    .convReq(convReq), .convChannel(convChannel), .convDiff(convDiff),
    .convDone(convDone), .convData(convData), .converterEnable(convEn),
    .conversionInterruptEnable(intEn), .resultWrite(resultWrite),
    .resultIndex(resultIndex), .resultData(resultData),
    .dmaRequest(dmaRequest));

  adcc_conv_model conv (.clk(clk), .rst(rst), .convReq(convReq),
    .slow(slow), .convDone(convDone), .convData(convData));

  always #5 clk = ~clk;

  task automatic chk(input string nm, input logic [31:0] e, g);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic wb(input logic [7:0] a, input logic we,
                    input logic [3:0] s, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    wbCyc   <= 1'b1;
    wbStb   <= 1'b1;
    wbWe    <= we;
    wbAdr   <= a;
    wbSel   <= s;
    wbDatIn <= d;
    do begin
      @(posedge clk);
      k++;
    end while (wbAck !== 1'b1 && k < 100);
    if (k >= 100) chk("wbAck", 32'h0000_0001, 32'h0000_0000);
    q = wbDatOut;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe  <= 1'b0;
  endtask

  task automatic rd(input string nm, input logic [7:0] a,
                    input logic [31:0] e);
    wb(a, 1'b0, 4'hf, 32'h0000_0000);
    chk(nm, e, q);
  endtask

  // Expected channel order: even ones only in differential mode
  task automatic plan(input logic [7:0] m, input logic d, input int md);
    chans.delete();
    dq.delete();
    for (int i = 0; i < 8; i++)
      if (m[i] && !(d && i % 2)) chans.push_back(i);
    if (md < 2) chans = '{chans[0]};
    reqIdx = 0;
    resIdx = 0;
  endtask

  task automatic wait_res(input int n);
    int k;
    k = 0;
    while (resIdx < n && k < 2000) begin
      @(posedge clk);
      k++;
    end
    if (k >= 2000) chk("results", n, resIdx);
    repeat (4) @(posedge clk);
  endtask

  function automatic logic [11:0] cmd(input logic f, st, d, dm, tr,
                                      input logic [1:0] tc, md);
    // f is the interrupt enable; every caller keeps it clear
    cmd = {st, d, dm, tr, tc, 2'b00, md, f, 1'b1};
  endfunction

  function automatic logic [15:0] fmtRes(input logic [11:0] d, input s);
    if (s) return {{4{~d[11]}}, ~d[11], d[10:0]};
    return {4'h0, d};
  endfunction

  always @(posedge clk) begin
    if (!rst && convReq) begin
      if (!running) chk("convReq", 32'h0000_0000, 32'h0000_0001);
      else chk("convChannel", chans[reqIdx % chans.size()],
               {29'h0, convChannel});
      chk("convDiff", curDiff, {31'h0, convDiff});
      reqIdx++;
    end
    if (!rst && convDone && running) dq.push_back(convData);
    if (!rst && (resultWrite || dmaRequest)) begin
      if (dq.size() == 0) chk("resultWrite", 32'h0000_0000, 32'h0000_0001);
      else begin
        chk("resultIndex", chans[resIdx % chans.size()],
            {29'h0, resultIndex});
        chk("resultData", fmtRes(dq.pop_front(), curFmt),
            {16'h0, resultData});
        chk("dmaRequest", curDma, {31'h0, dmaRequest});
      end
      resIdx++;
    end
  end

  initial begin
    repeat (30000) @(posedge clk);
    n_errors++;
    end_of_test();
  end

  initial begin
    seed = 32'h2e80631c;
    {clk, wbCyc, wbStb, wbWe, pin, slow, running} = 7'h00;
    {curFmt, curDma, curDiff} = 3'h0;
    {wbAdr, wbSel, wbDatIn} = 44'h0;
    rst = 1'b1;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rd("ctrl", `ADCC_CTRL_OFF, 32'h0000_0000);
    rd("chen", `ADCC_CHEN_OFF, 32'h0000_0000);
    wb(8'h28, 1'b1, 4'hf, 32'hffff_ffff);
    rd("unmapped", 8'h28, 32'h0000_0000);
    wb(`ADCC_CTRL_OFF, 1'b1, 4'hf, 32'hffff_f7ff);
    rd("ctrl", `ADCC_CTRL_OFF, 32'h8000_07cf);
    chk("convEn", 32'h0000_0001, {31'h0, convEn});
    chk("intEn", 32'h0000_0001, {31'h0, intEn});
    wb(`ADCC_CTRL_OFF, 1'b1, 4'h7, 32'h0000_0000);
    rd("ctrl", `ADCC_CTRL_OFF, 32'h8000_0000);
    wb(`ADCC_CTRL_OFF, 1'b1, 4'hf, 32'h0000_0000);
    $display("test registers done");
    // One-shot modes, including the reserved code, then continuous
    for (int m = 0; m < 4; m++) begin
      en = 8'($random(seed)) | 8'h01;
      c = 32'($random(seed)) & 32'h8000_0600;
      if (m == 3) c[10] = 1'b0;
      slow <= (m % 2 == 1);
      wb(`ADCC_CHEN_OFF, 1'b1, 4'hf, {24'h0, en});
      rd("chen", `ADCC_CHEN_OFF, {24'h0, en});
      plan(en, c[10], m);
      {curFmt, curDiff, curDma} = {c[31], c[10], c[9]};
      running = 1'b1;
      // Interrupt enable stays clear whenever DMA is on
      c[11:0] = cmd(1'b0, 1'b1, c[10], c[9], 1'b0, 2'h0, 2'(m));
      wb(`ADCC_CTRL_OFF, 1'b1, 4'hf, c);
      c[11] = 1'b0;
      if (m < 3) begin
        wait_res(chans.size());
        chk("reqCount", chans.size(), reqIdx);
      end else begin
        wait_res(chans.size() + 2);
        // Keep watching through the stop: a result in flight may land
        wb(`ADCC_CTRL_OFF, 1'b1, 4'hf, c);
        repeat (60) @(posedge clk);
      end
      running = 1'b0;
      rd("ctrl", `ADCC_CTRL_OFF, c);
      $display("test mode %0d done", m);
    end
    // Edge condition set before the trigger is armed, so a level event
    // of the old condition cannot set the start flag
    wb(`ADCC_CTRL_OFF, 1'b1, 4'hf, 32'h0000_00c0);
    slow <= 1'b0;
    en = 8'($random(seed)) | 8'h01;
    wb(`ADCC_CHEN_OFF, 1'b1, 4'hf, {24'h0, en});
    plan(en, 1'b0, 2);
    {curFmt, curDiff, curDma} = 3'h0;
    c = {20'h0, cmd(1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 2'h3, 2'h2)};
    wb(`ADCC_CTRL_OFF, 1'b1, 4'hf, c);
    repeat (20) @(posedge clk);
    rd("ctrl", `ADCC_CTRL_OFF, c);
    running = 1'b1;
    pin <= 1'b1;
    wait_res(chans.size());
    running = 1'b0;
    rd("ctrl", `ADCC_CTRL_OFF, c);
    // Falling edge of the pin starts a second scan
    plan(en, 1'b0, 2);
    c = {20'h0, cmd(1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 2'h2, 2'h2)};
    wb(`ADCC_CTRL_OFF, 1'b1, 4'hf, c);
    running = 1'b1;
    pin <= 1'b0;
    wait_res(chans.size());
    running = 1'b0;
    chk("fallCount", chans.size(), reqIdx);
    rd("ctrl", `ADCC_CTRL_OFF, c);
    $display("test start pin done");
    end_of_test();
  end
endmodule

`default_nettype wire
